/* pdhs_defines.svh */
// Purpose: Constants of the hotswap supervisor (offsets, fields, timing)
// Assumes: 40 MHz core clock
// Notes:   Included by bare name; definitions only
`ifndef PDHS_DEFINES_SVH
`define PDHS_DEFINES_SVH

`define PDHS_CLK_MHZ         40
`define PDHS_DEGLITCH_US     1650
`define PDHS_DEGLITCH_CYC    (`PDHS_DEGLITCH_US * `PDHS_CLK_MHZ)
`define PDHS_INRUSH_MIN_US   81500
`define PDHS_INRUSH_MIN_CYC  (`PDHS_INRUSH_MIN_US * `PDHS_CLK_MHZ)
`define PDHS_TMR_W           22

`define PDHS_ADDR_W          8
`define PDHS_OFS_CTRL        8'h00
`define PDHS_OFS_STATUS      8'h04
`define PDHS_OFS_EVENT       8'h08

`define PDHS_CTRL_FORCE_OFF  0
`define PDHS_CTRL_DET_BLOCK  1
`define PDHS_CTRL_RST        2'h0

`define PDHS_EVT_RETURN      0
`define PDHS_EVT_THERMAL     1
`define PDHS_EVT_UNDERVOLTAGE_LOCKOUT        2
`define PDHS_EVT_ADAPTER     3

`define PDHS_RESP_OKAY       2'h0
`define PDHS_RESP_SLVERR     2'h2

`endif

/* pdhs_pkg.sv */
// Purpose: Types of the hotswap supervisor
// Assumes: Constants live in pdhs_defines.svh
// Notes:   Open-drain groups are ordered converter, high, low, type
package pdhs_pkg;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_INRUSH = 5'h02,
		ST_OPER   = 5'h04,
		ST_HOT    = 5'h08,
		ST_SPARE  = 5'h10
	} pdhs_state_type;

	typedef struct packed {
		logic [3:0] drain_rb;
		logic [1:0] alloc_lvl;
		logic       pse_plusplus;
		logic       pse_type_hi;
		logic       inrush_below_limit;
		logic       return_node_fault;
		logic       undervoltage_lockout;
		logic       thermal_shutdown;
		logic       detect_disable_in;
		logic       adapter_detect_in;
	} pdhs_pins_type;

	typedef struct packed {
		logic converter_enable_out;
		logic alloc_code_high;
		logic alloc_code_low;
		logic source_type_flag;
	} pdhs_od_type;

endpackage : pdhs_pkg

/* pdhs_sync.sv */
// Purpose: Two-stage synchroniser for a vector of pin levels
// Assumes: Inputs are quasi-static levels, not buses
// Notes:   Stage one is read only by stage two
`timescale 1ns/1ps
module pdhs_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : pdhs_sync

/* pdhs_timer.sv */
// Purpose: Run-while-high interval timer
// Assumes: LIMIT of at least one cycle
// Notes:   Done rises in the LIMIT-th consecutive run cycle, holds while run
`timescale 1ns/1ps
module pdhs_timer #(
	parameter int unsigned LIMIT = 1,
	parameter int          W     = 22
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic run,
	output      logic done
);
	logic [W-1:0] cnt_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (!run) begin
			cnt_ff <= '0;
		end else if (!done) begin
			cnt_ff <= cnt_ff + W'(1);
		end
	end

	assign done = run && (cnt_ff == W'(LIMIT - 1));
endmodule : pdhs_timer

/* pdhs_supervisor.sv */
// Purpose: Hotswap switch supervisor with AXI4-Lite control
// Assumes: Comparator results arrive as asynchronous logic levels
// Notes:   Open-drain pins drive low only; od_o is always zero
`timescale 1ns/1ps
`include "pdhs_defines.svh"
module pdhs_supervisor #(
	parameter int unsigned DEGLITCH_CYC = `PDHS_DEGLITCH_CYC,
	parameter int unsigned INRUSH_CYC   = `PDHS_INRUSH_MIN_CYC
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire pdhs_pkg::pdhs_pins_type  pins_i,
	output      pdhs_pkg::pdhs_od_type    od_o,
	output      pdhs_pkg::pdhs_od_type    od_oe,
	output      logic                     pass_switch_on,
	output      logic                     inrush_limit_sel,
	output      logic                     class_reg_en,
	output      logic                     startup_src_en,
	output      logic                     hold_pulse_en,
	output      logic                     detect_sig_en,
	input  wire logic [`PDHS_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output      logic                     s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output      logic                     s_axi_wready,
	output      logic [1:0]               s_axi_bresp,
	output      logic                     s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [`PDHS_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output      logic                     s_axi_arready,
	output      logic [31:0]              s_axi_rdata,
	output      logic [1:0]               s_axi_rresp,
	output      logic                     s_axi_rvalid,
	input  wire logic                     s_axi_rready
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	pdhs_pkg::pdhs_pins_type pin_s;
	pdhs_pkg::pdhs_pins_type pin_prev_ff;
	pdhs_pkg::pdhs_state_type state_ff;
	pdhs_pkg::pdhs_state_type nxt_state;
	logic        need_min_ff;
	logic [2:0]  alloc_oe_ff;
	logic [2:0]  nxt_alloc;
	logic [1:0]  ctrl_ff;
	logic [3:0]  evt_ff;
	logic [3:0]  evt_set;
	logic [3:0]  evt_clr;
	logic        den_low;
	logic        force_off;
	logic        dgl_done;
	logic        inr_done;
	logic        fault_exit;
	logic        aw_got_ff;
	logic        w_got_ff;
	logic [`PDHS_ADDR_W-1:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic        wr_go;

	function automatic logic reg_mapped(input logic [`PDHS_ADDR_W-1:0] a);
		reg_mapped = (a == `PDHS_OFS_CTRL) || (a == `PDHS_OFS_STATUS) ||
			(a == `PDHS_OFS_EVENT);
	endfunction : reg_mapped

	pdhs_sync #(
		.W ($bits(pdhs_pkg::pdhs_pins_type))
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        (pins_i),
		.q        (pin_s)
	);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_prev_ff <= '0;
		end else begin
			pin_prev_ff <= pin_s;
		end
	end

	// Detect-disable is a comparator: high means above its threshold
	assign den_low = !pin_s.detect_disable_in;

	assign force_off = pin_s.adapter_detect_in ||
		(den_low && !pin_s.undervoltage_lockout) ||
		pin_s.thermal_shutdown || pin_s.undervoltage_lockout ||
		ctrl_ff[`PDHS_CTRL_FORCE_OFF];

	// deglitch timer, counts only while in operation
	pdhs_timer #(
		.LIMIT (DEGLITCH_CYC),
		.W     (`PDHS_TMR_W)
	) u_dgl (
		.core_clk (core_clk),
		.rst      (rst),
		.run      ((state_ff == pdhs_pkg::ST_OPER) && pin_s.return_node_fault),
		.done     (dgl_done)
	);

	pdhs_timer #(
		.LIMIT (INRUSH_CYC),
		.W     (`PDHS_TMR_W)
	) u_inr (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (state_ff == pdhs_pkg::ST_INRUSH),
		.done     (inr_done)
	);

	assign fault_exit = (state_ff == pdhs_pkg::ST_OPER) && !force_off && dgl_done;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			pdhs_pkg::ST_IDLE: begin
				if (pin_s.thermal_shutdown) begin
					nxt_state = pdhs_pkg::ST_HOT;
				end else if (!force_off) begin
					nxt_state = pdhs_pkg::ST_INRUSH;
				end
			end
			pdhs_pkg::ST_INRUSH: begin
				if (pin_s.thermal_shutdown) begin
					nxt_state = pdhs_pkg::ST_HOT;
				end else if (force_off) begin
					nxt_state = pdhs_pkg::ST_IDLE;
				end else if (pin_s.inrush_below_limit && (!need_min_ff || inr_done)) begin
					nxt_state = pdhs_pkg::ST_OPER;
				end
			end
			pdhs_pkg::ST_OPER: begin
				if (pin_s.thermal_shutdown) begin
					nxt_state = pdhs_pkg::ST_HOT;
				end else if (force_off) begin
					nxt_state = pdhs_pkg::ST_IDLE;
				end else if (dgl_done) begin
					nxt_state = pdhs_pkg::ST_INRUSH;
				end
			end
			pdhs_pkg::ST_HOT: begin
				if (!pin_s.thermal_shutdown) begin
					nxt_state = force_off ? pdhs_pkg::ST_IDLE : pdhs_pkg::ST_INRUSH;
				end
			end
			default: begin
				nxt_state = pdhs_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= pdhs_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// fault recovery skips the minimum delay
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			need_min_ff <= 1'b1;
		end else if (fault_exit) begin
			need_min_ff <= 1'b0;
		end else if (state_ff != pdhs_pkg::ST_OPER && state_ff != pdhs_pkg::ST_INRUSH) begin
			need_min_ff <= 1'b1;
		end
	end

	assign pass_switch_on   = (state_ff == pdhs_pkg::ST_INRUSH) || (state_ff == pdhs_pkg::ST_OPER);
	assign inrush_limit_sel = (state_ff != pdhs_pkg::ST_OPER);
	assign class_reg_en     = (state_ff != pdhs_pkg::ST_HOT);
	assign startup_src_en   = (state_ff != pdhs_pkg::ST_HOT);
	assign hold_pulse_en    = (state_ff != pdhs_pkg::ST_HOT);
	assign detect_sig_en    = (state_ff == pdhs_pkg::ST_IDLE) && !den_low &&
		!ctrl_ff[`PDHS_CTRL_DET_BLOCK];

	// allocation code from type and power
	always_comb begin
		if (pin_s.adapter_detect_in) begin
			nxt_alloc = 3'h4;
		end else if (state_ff != pdhs_pkg::ST_OPER) begin
			nxt_alloc = 3'h0;
		end else if (pin_s.pse_plusplus) begin
			nxt_alloc = 3'h6;
		end else begin
			nxt_alloc = {pin_s.alloc_lvl, pin_s.pse_type_hi};
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alloc_oe_ff <= 3'h0;
		end else begin
			alloc_oe_ff <= nxt_alloc;
		end
	end

	// open drain, enable means pin pulled low
	assign od_o  = '0;
	assign od_oe = {state_ff == pdhs_pkg::ST_INRUSH, alloc_oe_ff};

	// Events: set wins over a same-cycle clear
	assign evt_set[`PDHS_EVT_RETURN]  = fault_exit;
	assign evt_set[`PDHS_EVT_THERMAL] = pin_s.thermal_shutdown && !pin_prev_ff.thermal_shutdown;
	assign evt_set[`PDHS_EVT_UNDERVOLTAGE_LOCKOUT]    = pin_s.undervoltage_lockout &&
		!pin_prev_ff.undervoltage_lockout;
	assign evt_set[`PDHS_EVT_ADAPTER] = pin_s.adapter_detect_in && !pin_prev_ff.adapter_detect_in;
	assign evt_clr = (wr_go && aw_addr_ff == `PDHS_OFS_EVENT && w_strb_ff[0]) ?
		w_data_ff[3:0] : 4'h0;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			evt_ff <= 4'h0;
		end else begin
			evt_ff <= (evt_ff & ~evt_clr) | evt_set;
		end
	end

	// AXI4-Lite write path; address and data accepted in either order
	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign wr_go         = aw_got_ff && w_got_ff && !bvalid_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_got_ff  <= 1'b0;
			aw_addr_ff <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_ff  <= 1'b1;
			aw_addr_ff <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_got_ff  <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			w_got_ff  <= 1'b0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_ff  <= 1'b1;
			w_data_ff <= s_axi_wdata;
			w_strb_ff <= s_axi_wstrb;
		end else if (wr_go) begin
			w_got_ff  <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= `PDHS_CTRL_RST;
		end else if (wr_go && aw_addr_ff == `PDHS_OFS_CTRL && w_strb_ff[0]) begin
			ctrl_ff <= w_data_ff[1:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `PDHS_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= reg_mapped(aw_addr_ff) ? `PDHS_RESP_OKAY : `PDHS_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;

	// AXI4-Lite read path, one outstanding read
	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= `PDHS_RESP_OKAY;
			rdata_ff  <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= reg_mapped(s_axi_araddr) ? `PDHS_RESP_OKAY : `PDHS_RESP_SLVERR;
			unique case (s_axi_araddr)
				`PDHS_OFS_CTRL:   rdata_ff <= {30'h0, ctrl_ff};
				`PDHS_OFS_STATUS: rdata_ff <= {10'h0, pin_s, need_min_ff,
					inrush_limit_sel, pass_switch_on, state_ff};
				`PDHS_OFS_EVENT:  rdata_ff <= {28'h0, evt_ff};
				default:          rdata_ff <= '0;
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp  = rresp_ff;
	assign s_axi_rdata  = rdata_ff;

	// Helper counters, read only by the checks below
	int unsigned flt_age_ff;
	int unsigned inr_age_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flt_age_ff <= 0;
		end else if (state_ff == pdhs_pkg::ST_OPER && pin_s.return_node_fault) begin
			flt_age_ff <= flt_age_ff + 1;
		end else begin
			flt_age_ff <= 0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			inr_age_ff <= 0;
		end else if (state_ff == pdhs_pkg::ST_INRUSH) begin
			inr_age_ff <= inr_age_ff + 1;
		end else begin
			inr_age_ff <= 0;
		end
	end

	dgl_timing_a: assert property (
		(state_ff == pdhs_pkg::ST_OPER) && !pin_s.thermal_shutdown && !force_off ##1
		(state_ff == pdhs_pkg::ST_INRUSH) |-> $past(flt_age_ff) == DEGLITCH_CYC - 1)
		else $error("Return fault acted before deglitch time");
	dgl_short_a: assert property (
		(state_ff == pdhs_pkg::ST_OPER) && !force_off && !pin_s.thermal_shutdown &&
		(flt_age_ff + 1 < DEGLITCH_CYC) |=> state_ff == pdhs_pkg::ST_OPER)
		else $error("Short return excursion left operation");
	fault_pg_a: assert property (
		fault_exit |=> od_oe.converter_enable_out && !need_min_ff)
		else $error("Return fault did not pull converter enable");
	undervoltage_lockout_restart_a: assert property (
		(state_ff == pdhs_pkg::ST_IDLE) && !force_off && !pin_s.thermal_shutdown
		|=> (state_ff == pdhs_pkg::ST_INRUSH) && inrush_limit_sel && need_min_ff)
		else $error("Restart not in inrush");
	hot_gates_a: assert property (
		$rose(pin_s.thermal_shutdown) |=> !pass_switch_on && !class_reg_en &&
		!startup_src_en && !hold_pulse_en)
		else $error("Thermal shutdown left a source enabled");
	hot_exit_a: assert property (
		(state_ff == pdhs_pkg::ST_HOT) && !pin_s.thermal_shutdown
		|=> state_ff != pdhs_pkg::ST_OPER)
		else $error("Thermal exit skipped inrush");
	den_off_a: assert property (
		(state_ff == pdhs_pkg::ST_OPER) && den_low |=> !pass_switch_on)
		else $error("Detect-disable did not open switch");
	force_off_a: assert property (
		force_off |=> !pass_switch_on)
		else $error("Switch on during force-off");
	inrush_pg_a: assert property (
		(state_ff == pdhs_pkg::ST_INRUSH) |-> od_oe.converter_enable_out)
		else $error("Converter enable released in inrush");
	oper_pg_a: assert property (
		(state_ff == pdhs_pkg::ST_OPER) |-> !od_oe.converter_enable_out && !inrush_limit_sel)
		else $error("Converter enable held after inrush");
	type_code_a: assert property (
		(state_ff == pdhs_pkg::ST_OPER) && !pin_s.adapter_detect_in && !pin_s.pse_plusplus
		|=> od_oe.source_type_flag == $past(pin_s.pse_type_hi))
		else $error("Source type flag wrong");
	adapter_code_a: assert property (
		pin_s.adapter_detect_in |=> od_oe[2:0] == 3'h4)
		else $error("Adapter code wrong");
	pp_code_a: assert property (
		(state_ff == pdhs_pkg::ST_OPER) && pin_s.pse_plusplus && !pin_s.adapter_detect_in
		|=> od_oe[2:0] == 3'h6)
		else $error("High-power source code wrong");
	det_block_a: assert property (
		den_low |-> !detect_sig_en)
		else $error("Detection signature with disable low");
	min_delay_a: assert property (
		(state_ff == pdhs_pkg::ST_INRUSH) && need_min_ff ##1 (state_ff == pdhs_pkg::ST_OPER)
		|-> $past(inr_age_ff) >= INRUSH_CYC - 1)
		else $error("Converter enabled before minimum inrush");
	od_low_a: assert property (
		od_o == '0)
		else $error("Open-drain output driven high");
	reset_idle_a: assert property (
		$fell(rst) |-> (state_ff == pdhs_pkg::ST_IDLE) && !pass_switch_on)
		else $error("Not idle after reset");
endmodule : pdhs_supervisor

/* pdhs_far_side.sv */
// Purpose: Open-drain nets as seen by the source and the downstream converter
// Assumes: Pull-ups on all four nets
// Notes:   A released net reads high, never the last driven level
`timescale 1ns/1ps
module pdhs_far_side (
	input  wire pdhs_pkg::pdhs_od_type od_o,
	input  wire pdhs_pkg::pdhs_od_type od_oe,
	output      logic [3:0]            pin_lvl,
	output      logic [2:0]            load_code
);
	assign pin_lvl = ~od_oe | (od_oe & od_o);
	assign load_code = ~pin_lvl[2:0];
endmodule : pdhs_far_side

/* pd_hotswap_supervisor_tb.sv */
// Purpose: Self-checking bench of the hotswap supervisor
// Assumes: Short timer parameters, 40 MHz clock
// Notes:   Pin changes get five edges to pass the synchroniser and state flop
`timescale 1ns/1ps
`include "pdhs_defines.svh"
module pd_hotswap_supervisor_tb;
	localparam int DG = 8;
	localparam int IR = 20;
	logic                    core_clk;
	logic                    rst;
	pdhs_pkg::pdhs_pins_type pins;
	pdhs_pkg::pdhs_pins_type pins_w;
	pdhs_pkg::pdhs_od_type   od_o;
	pdhs_pkg::pdhs_od_type   od_oe;
	logic [3:0]              pin_lvl;
	logic [2:0]              load_code;
	logic                    pass_switch_on;
	logic                    inrush_limit_sel;
	logic                    class_reg_en;
	logic                    startup_src_en;
	logic                    hold_pulse_en;
	logic                    detect_sig_en;
	logic [7:0]              s_axi_awaddr;
	logic                    s_axi_awvalid;
	logic                    s_axi_awready;
	logic [31:0]             s_axi_wdata;
	logic [3:0]              s_axi_wstrb;
	logic                    s_axi_wvalid;
	logic                    s_axi_wready;
	logic [1:0]              s_axi_bresp;
	logic                    s_axi_bvalid;
	logic                    s_axi_bready;
	logic [7:0]              s_axi_araddr;
	logic                    s_axi_arvalid;
	logic                    s_axi_arready;
	logic [31:0]             s_axi_rdata;
	logic [1:0]              s_axi_rresp;
	logic                    s_axi_rvalid;
	logic                    s_axi_rready;
	logic [31:0]             rd;
	logic [1:0]              rs;
	logic [1:0]              lv;
	logic                    ty;
	logic                    pp;
	int                      mismatches;
	int                      n_checks;

	always_comb begin
		pins_w = pins;
		pins_w.drain_rb = pin_lvl;
	end

	pdhs_supervisor #(.DEGLITCH_CYC(DG), .INRUSH_CYC(IR)) uut (
		.core_clk(core_clk), .rst(rst), .pins_i(pins_w), .od_o(od_o), .od_oe(od_oe),
		.pass_switch_on(pass_switch_on), .inrush_limit_sel(inrush_limit_sel),
		.class_reg_en(class_reg_en), .startup_src_en(startup_src_en),
		.hold_pulse_en(hold_pulse_en), .detect_sig_en(detect_sig_en),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);

	pdhs_far_side far (.od_o(od_o), .od_oe(od_oe), .pin_lvl(pin_lvl), .load_code(load_code));

	function automatic logic [2:0] alloc_exp(input logic ad, input logic op, input logic p,
		input logic [1:0] l, input logic t);
		if (ad)
			return 3'h4;
		if (!op)
			return 3'h0;
		if (p)
			return 3'h6;
		return {l, t};
	endfunction : alloc_exp

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wrap_up();
		if (mismatches == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	// Ends at a falling edge so that sampled outputs have settled
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : step

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_d;
		logic w_d;
		logic aw_t;
		logic w_t;
		aw_d = 1'b0;
		w_d = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Ready is judged before the edge; each channel is released just after its own edge
		while (!(aw_d && w_d)) begin
			@(negedge core_clk);
			aw_t = !aw_d && (s_axi_awready === 1'b1);
			w_t = !w_d && (s_axi_wready === 1'b1);
			@(posedge core_clk);
			if (aw_t) begin
				aw_d = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (w_t) begin
				w_d = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(negedge core_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		@(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge core_clk); while (s_axi_arready !== 1'b1);
		@(posedge core_clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge core_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge core_clk);
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic oper_chk();
		step(IR + 10);
		chk("limit", 1'b0, inrush_limit_sel);
		chk("conv_oe", 1'b0, od_oe.converter_enable_out);
		chk("conv_pin", 1'b1, pin_lvl[3]);
	endtask : oper_chk

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Whole run is a few hundred cycles; this limit only catches a hang
	initial begin
		#(25 * 20000);
		mismatches++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		pins = '0;
		pins.undervoltage_lockout = 1'b1;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		mismatches = 0;
		n_checks = 0;
		void'($urandom(43839));
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		step(5);
		chk("pass", 1'b0, pass_switch_on);
		chk("sig", 1'b0, detect_sig_en);
		@(posedge core_clk);
		pins.detect_disable_in <= 1'b1;
		step(5);
		chk("sig", 1'b1, detect_sig_en);
		axi_wr(`PDHS_OFS_CTRL, 32'h0000_0002, rs);
		step(1);
		chk("sig", 1'b0, detect_sig_en);
		axi_wr(`PDHS_OFS_CTRL, 32'h0000_0000, rs);
		@(posedge core_clk);
		pins.undervoltage_lockout <= 1'b0;
		pins.inrush_below_limit <= 1'b1;
		step(5);
		chk("on_lim", 2'h3, {pass_switch_on, inrush_limit_sel});
		chk("conv_oe", 1'b1, od_oe.converter_enable_out);
		step(8);
		chk("limit", 1'b1, inrush_limit_sel);
		oper_chk();
		axi_rd(`PDHS_OFS_STATUS, rd, rs);
		chk("status", 7'h24, rd[6:0]);
		axi_rd(8'h0c, rd, rs);
		chk("rresp", 2'h2, rs);
		chk("rdata", 32'h0000_0000, rd);
		axi_wr(8'h10, 32'h0000_0001, rs);
		chk("bresp", 2'h2, rs);
		for (int i = 0; i < 6; i++) begin
			lv = 2'($urandom);
			ty = 1'($urandom);
			pp = (i == 0) ? 1'b1 : 1'($urandom);
			@(posedge core_clk);
			pins.alloc_lvl <= lv;
			pins.pse_type_hi <= ty;
			pins.pse_plusplus <= pp;
			step(5);
			chk("alloc", alloc_exp(1'b0, 1'b1, pp, lv, ty), od_oe[2:0]);
			chk("alloc_pin", 3'(~alloc_exp(1'b0, 1'b1, pp, lv, ty)), pin_lvl[2:0]);
			chk("load", alloc_exp(1'b0, 1'b1, pp, lv, ty), load_code);
		end
		@(posedge core_clk);
		pins.return_node_fault <= 1'b1;
		repeat (5) @(posedge core_clk);
		pins.return_node_fault <= 1'b0;
		step(5);
		chk("limit", 1'b0, inrush_limit_sel);
		@(posedge core_clk);
		pins.return_node_fault <= 1'b1;
		pins.inrush_below_limit <= 1'b0;
		step(DG + 6);
		chk("limit", 1'b1, inrush_limit_sel);
		chk("conv_oe", 1'b1, od_oe.converter_enable_out);
		@(posedge core_clk);
		pins.return_node_fault <= 1'b0;
		pins.inrush_below_limit <= 1'b1;
		step(5);
		chk("limit", 1'b0, inrush_limit_sel);
		@(posedge core_clk);
		pins.thermal_shutdown <= 1'b1;
		step(5);
		chk("hot_en", 4'h0, {pass_switch_on, class_reg_en, startup_src_en, hold_pulse_en});
		@(posedge core_clk);
		pins.thermal_shutdown <= 1'b0;
		step(5);
		chk("on_lim", 2'h3, {pass_switch_on, inrush_limit_sel});
		oper_chk();
		@(posedge core_clk);
		pins.undervoltage_lockout <= 1'b1;
		step(5);
		chk("pass", 1'b0, pass_switch_on);
		@(posedge core_clk);
		pins.undervoltage_lockout <= 1'b0;
		step(5);
		chk("on_lim", 2'h3, {pass_switch_on, inrush_limit_sel});
		oper_chk();
		@(posedge core_clk);
		pins.detect_disable_in <= 1'b0;
		step(5);
		chk("pass", 1'b0, pass_switch_on);
		@(posedge core_clk);
		pins.detect_disable_in <= 1'b1;
		oper_chk();
		@(posedge core_clk);
		pins.adapter_detect_in <= 1'b1;
		step(5);
		chk("pass", 1'b0, pass_switch_on);
		chk("alloc", alloc_exp(1'b1, 1'b0, pp, lv, ty), od_oe[2:0]);
		chk("alloc_pin", 3'h3, pin_lvl[2:0]);
		@(posedge core_clk);
		pins.adapter_detect_in <= 1'b0;
		oper_chk();
		axi_wr(`PDHS_OFS_CTRL, 32'h0000_0001, rs);
		step(3);
		chk("pass", 1'b0, pass_switch_on);
		axi_wr(`PDHS_OFS_CTRL, 32'h0000_0000, rs);
		oper_chk();
		// Low byte strobe clear: the write must not land
		s_axi_wstrb <= 4'he;
		axi_wr(`PDHS_OFS_CTRL, 32'h0000_0001, rs);
		step(3);
		chk("pass", 1'b1, pass_switch_on);
		chk("bresp", 2'h0, rs);
		s_axi_wstrb <= 4'hf;
		axi_rd(`PDHS_OFS_EVENT, rd, rs);
		chk("event", 4'hf, rd[3:0]);
		axi_wr(`PDHS_OFS_EVENT, 32'h0000_000f, rs);
		axi_rd(`PDHS_OFS_EVENT, rd, rs);
		chk("event", 4'h0, rd[3:0]);
		wrap_up();
	end
endmodule : pd_hotswap_supervisor_tb
